// *** ast_pkg.sv ***
// constants shared by the asynchronous serial transceiver
// assumes one bus clock; register offsets and bit positions are local
package ast_pkg;

  // register offsets on the plain register port
  localparam logic [2:0] REG_BAUD_LO = 3'h0;
  localparam logic [2:0] REG_BAUD_HI = 3'h1;
  localparam logic [2:0] REG_CTRL1 = 3'h2;
  localparam logic [2:0] REG_CTRL2 = 3'h3;
  localparam logic [2:0] REG_STATUS1 = 3'h4;
  localparam logic [2:0] REG_CTRL3 = 3'h5;
  localparam logic [2:0] REG_DATA = 3'h6;

  // control bit positions
  localparam int C1_LONG_BREAK = 0;
  localparam int C1_NINE_BIT = 4;
  localparam int C2_SEND_BREAK = 0;
  localparam int C2_RX_ENABLE = 2;
  localparam int C2_TX_ENABLE = 3;
  localparam int C3_TX_INVERT = 4;
  localparam int C3_RX_INVERT = 5;
  localparam int C3_TX_NINTH = 6;
  localparam int C3_RX_NINTH = 7;

  // status bit positions
  localparam int S1_PARITY = 0;
  localparam int S1_FRAMING = 1;
  localparam int S1_NOISE = 2;
  localparam int S1_OVERRUN = 3;
  localparam int S1_RX_FULL = 5;
  localparam int S1_TX_DONE = 6;
  localparam int S1_TX_EMPTY = 7;

  localparam logic [4:0] BAUD_HI_MASK = 5'h1F;
  localparam logic [12:0] BAUD_RESET = 13'h0000;

  // frame lengths in bit times
  localparam logic [3:0] FRAME_LEN_8 = 4'hA;
  localparam logic [3:0] FRAME_LEN_9 = 4'hB;
  localparam logic [3:0] BREAK_EXTRA = 4'h3;
  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  localparam logic [3:0] DATA_BITS_9 = 4'h9;

  // sixteenth-bit slots, stored as slot number minus one
  localparam logic [3:0] SLOT_1 = 4'h0;
  localparam logic [3:0] SLOT_3 = 4'h2;
  localparam logic [3:0] SLOT_5 = 4'h4;
  localparam logic [3:0] SLOT_7 = 4'h6;
  localparam logic [3:0] SLOT_8 = 4'h7;
  localparam logic [3:0] SLOT_9 = 4'h8;
  localparam logic [3:0] SLOT_10 = 4'h9;
  localparam logic [3:0] SLOT_11 = 4'hA;
  localparam logic [3:0] SLOT_16 = 4'hF;

  localparam logic [2:0] HIST_ONES = 3'h7;
  localparam logic [2:0] HIST_CLEAR = 3'h0;
  localparam logic [1:0] START_MAJORITY = 2'h2;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} ast_rx_state_type;

  // frame length: data frame, or break with optional long extension
  function automatic logic [3:0] ast_frame_len(input logic nine,
                                               input logic brk,
                                               input logic long_brk);
    logic [3:0] len;
    len = nine ? FRAME_LEN_9 : FRAME_LEN_8;
    if (brk && long_brk) begin
      len = len + BREAK_EXTRA;
    end
    return len;
  endfunction

endpackage

// *** ast_core.sv ***
// asynchronous serial transceiver: baud generator, transmitter, receiver
// assumes a plain register port on CLK and a remote device on RXD/TXD
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
module ast_core
  import ast_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic RXD,
  output logic TXD,
  output logic TX_OE
);

  logic [12:0] baud_div;
  logic [12:0] baud_cnt;
  logic tick16;
  logic long_break_select, nine_bit_mode;
  logic tx_enable_bit, rx_enable_bit, send_break_ctl;
  logic tx_ninth_bit, tx_polarity_invert, rx_polarity_invert;
  logic [7:0] tx_data;
  logic tx_buffer_empty_flag, tx_complete_flag;
  logic preamble_q, break_q;
  logic [3:0] tx_rt, tx_left;
  logic [13:0] tx_shift, next_frame;
  logic [3:0] next_len;
  logic tx_cur, tx_busy;
  logic tx_bit_tick, tx_free, load_pre, load_brk, load_data, tx_done;
  logic rx_meta, rx_sync, rx_in, rx_edge;
  logic [2:0] rx_hist;
  ast_rx_state_type rx_state;
  logic [3:0] rx_rt, rt_n, rx_idx, rx_last;
  logic [1:0] rx_zeros, start_zeros;
  logic [1:0] rx_votes;
  logic rx_bit, rx_disagree, rx_any_one;
  logic rx_noise, rx_break;
  logic [8:0] rx_shift;
  logic rx_done, frame_fe, frame_nf;
  logic [7:0] rx_data;
  logic rx_ninth;
  logic rx_buffer_full_flag, overrun_flag, noise_flag, framing_error_flag;
  logic clear_armed;
  logic wr_ctrl2, wr_data, rd_status, rd_data, clear_seq;
  logic [7:0] status_byte;

  assign wr_ctrl2 = WR && (ADDR == REG_CTRL2);
  assign wr_data = WR && (ADDR == REG_DATA);
  assign rd_status = RD && (ADDR == REG_STATUS1);
  assign rd_data = RD && (ADDR == REG_DATA);
  assign clear_seq = rd_data && clear_armed;

  function automatic logic maj3(input logic a, input logic b,
                                input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction

  // control registers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      baud_div <= BAUD_RESET;
      long_break_select <= 1'b0;
      nine_bit_mode <= 1'b0;
      tx_enable_bit <= 1'b0;
      rx_enable_bit <= 1'b0;
      send_break_ctl <= 1'b0;
      tx_ninth_bit <= 1'b0;
      tx_polarity_invert <= 1'b0;
      rx_polarity_invert <= 1'b0;
      tx_data <= 8'h00;
    end else if (WR) begin
      case (ADDR)
        REG_BAUD_LO: baud_div[7:0] <= WDATA;
        REG_BAUD_HI: baud_div[12:8] <= WDATA[4:0] & BAUD_HI_MASK;
        REG_CTRL1: begin
          long_break_select <= WDATA[C1_LONG_BREAK];
          nine_bit_mode <= WDATA[C1_NINE_BIT];
        end
        REG_CTRL2: begin
          tx_enable_bit <= WDATA[C2_TX_ENABLE];
          rx_enable_bit <= WDATA[C2_RX_ENABLE];
          send_break_ctl <= WDATA[C2_SEND_BREAK];
        end
        REG_CTRL3: begin
          tx_ninth_bit <= WDATA[C3_TX_NINTH];
          tx_polarity_invert <= WDATA[C3_TX_INVERT];
          rx_polarity_invert <= WDATA[C3_RX_INVERT];
        end
        REG_DATA: tx_data <= WDATA;
        default: ;
      endcase
    end
  end

  // one generator shared by both directions; divisor zero holds it
  always_ff @(posedge CLK) begin
    if (!RST_N || baud_div == BAUD_RESET) begin
      baud_cnt <= BAUD_RESET;
      tick16 <= 1'b0;
    end else if (baud_cnt >= baud_div - 13'h0001) begin
      baud_cnt <= BAUD_RESET;
      tick16 <= 1'b1;
    end else begin
      baud_cnt <= baud_cnt + 13'h0001;
      tick16 <= 1'b0;
    end
  end

  // transmit bit clock: every sixteenth sample tick
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      tx_rt <= SLOT_1;
    end else if (tick16) begin
      tx_rt <= tx_rt + 4'h1;
    end
  end

  assign tx_bit_tick = tick16 && (tx_rt == SLOT_16);
  assign tx_free = tx_bit_tick && (tx_left == 4'h0);
  // preamble, then break, then data; data only while enabled
  assign load_pre = tx_free && preamble_q;
  assign load_brk = tx_free && !preamble_q && break_q;
  assign load_data = tx_free && !preamble_q && !break_q && tx_enable_bit
                     && !tx_buffer_empty_flag;
  assign tx_done = tx_free && tx_busy && !load_pre && !load_brk
                   && !load_data;

  always_comb begin
    next_len = ast_frame_len(nine_bit_mode, load_brk, long_break_select);
    if (load_brk) begin
      next_frame = 14'h0000;
    end else if (load_pre) begin
      next_frame = 14'h3FFF;
    end else if (nine_bit_mode) begin
      next_frame = {3'h0, 1'b1, tx_ninth_bit, tx_data, 1'b0};
    end else begin
      next_frame = {4'h0, 1'b1, tx_data, 1'b0};
    end
  end

  // transmit shifter
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      tx_cur <= 1'b1;
      tx_busy <= 1'b0;
      tx_left <= 4'h0;
      tx_shift <= 14'h0000;
    end else if (tx_bit_tick) begin
      if (tx_left != 4'h0) begin
        tx_cur <= tx_shift[0];
        tx_shift <= {1'b0, tx_shift[13:1]};
        tx_left <= tx_left - 4'h1;
      end else if (load_pre || load_brk || load_data) begin
        tx_cur <= next_frame[0];
        tx_shift <= {1'b0, next_frame[13:1]};
        tx_left <= next_len - 4'h1;
        tx_busy <= 1'b1;
      end else begin
        tx_cur <= 1'b1;
        tx_busy <= 1'b0;
      end
    end
  end

  // queued preamble and break characters
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      preamble_q <= 1'b0;
      break_q <= 1'b0;
    end else begin
      if (load_pre) begin
        preamble_q <= 1'b0;
      end
      if (load_brk) begin
        break_q <= send_break_ctl;
      end
      if (wr_ctrl2 && WDATA[C2_TX_ENABLE] && !tx_enable_bit) begin
        preamble_q <= 1'b1;
      end
      if (wr_ctrl2 && WDATA[C2_SEND_BREAK] && !send_break_ctl) begin
        break_q <= 1'b1;
      end
    end
  end

  // transmit flags: the hardware set is applied last so it wins
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      tx_buffer_empty_flag <= 1'b1;
      tx_complete_flag <= 1'b1;
    end else begin
      if (wr_data) begin
        tx_buffer_empty_flag <= 1'b0;
        tx_complete_flag <= 1'b0;
      end
      if (wr_ctrl2 && ((WDATA[C2_TX_ENABLE] && !tx_enable_bit) ||
                       (WDATA[C2_SEND_BREAK] && !send_break_ctl))) begin
        tx_complete_flag <= 1'b0;
      end
      if (load_data) begin
        tx_buffer_empty_flag <= 1'b1;
      end
      if (tx_done) begin
        tx_complete_flag <= 1'b1;
      end
    end
  end

  // pin stays owned while a frame runs or a preamble or break waits, even after disable
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      TXD <= 1'b1;
      TX_OE <= 1'b0;
    end else begin
      TXD <= tx_cur ^ tx_polarity_invert;
      TX_OE <= tx_enable_bit || tx_busy || preamble_q || break_q;
    end
  end

  // receive input synchroniser; inversion applied after it
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= RXD;
      rx_sync <= rx_meta;
    end
  end

  assign rx_in = rx_sync ^ rx_polarity_invert;
  assign rx_edge = tick16 && (rx_hist == HIST_ONES) && !rx_in;
  assign rt_n = rx_rt + 4'h1;
  assign start_zeros = rx_zeros + {1'b0, !rx_in};
  assign rx_bit = maj3(rx_votes[0], rx_votes[1], rx_in);
  assign rx_any_one = rx_votes[0] | rx_votes[1] | rx_in;
  assign rx_disagree = (rx_idx == 4'h0) ? rx_any_one :
                       !((rx_votes[0] == rx_votes[1]) &&
                         (rx_votes[1] == rx_in));
  assign rx_last = (nine_bit_mode ? DATA_BITS_9 : DATA_BITS_8) + 4'h1;

  // receive sampler; runs on after a framing error, storing is gated
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rx_state <= RX_IDLE;
      rx_hist <= HIST_CLEAR;
      rx_rt <= SLOT_1;
      rx_idx <= 4'h0;
      rx_zeros <= 2'h0;
      rx_votes <= 2'h0;
      rx_noise <= 1'b0;
      rx_break <= 1'b0;
      rx_shift <= 9'h000;
      rx_done <= 1'b0;
      frame_fe <= 1'b0;
      frame_nf <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (!rx_enable_bit) begin
        rx_state <= RX_IDLE;
        rx_hist <= HIST_CLEAR;
      end else if (tick16) begin
        rx_hist <= {rx_hist[1:0], rx_in};
        rx_rt <= rt_n;
        case (rx_state)
          RX_IDLE: begin
            if (rx_edge) begin
              rx_state <= RX_START;
              rx_rt <= SLOT_1;
              rx_idx <= 4'h0;
              rx_zeros <= 2'h0;
              rx_noise <= 1'b0;
              rx_break <= 1'b1;
            end
          end
          RX_START: begin
            if (rt_n == SLOT_3 || rt_n == SLOT_5) begin
              rx_zeros <= start_zeros;
              rx_noise <= rx_noise | rx_in;
            end else if (rt_n == SLOT_7) begin
              rx_noise <= rx_noise | rx_in;
              rx_state <= (start_zeros >= START_MAJORITY) ? RX_DATA
                                                         : RX_IDLE;
            end
          end
          RX_DATA: begin
            if (rx_edge) begin
              rx_rt <= SLOT_1;
              if (rt_n >= SLOT_11) begin
                rx_idx <= rx_idx + 4'h1;
              end
            end else begin
              if (rt_n == SLOT_8) begin
                rx_votes[0] <= rx_in;
              end
              if (rt_n == SLOT_9) begin
                rx_votes[1] <= rx_in;
              end
              if (rt_n == SLOT_16) begin
                rx_idx <= rx_idx + 4'h1;
              end
              if (rt_n == SLOT_10) begin
                rx_noise <= rx_noise | rx_disagree;
                if (rx_idx != 4'h0 && rx_idx != rx_last) begin
                  rx_shift <= {rx_bit, rx_shift[8:1]};
                  if (rx_bit) begin
                    rx_break <= 1'b0;
                  end
                end
                if (rx_idx == rx_last) begin
                  rx_done <= 1'b1;
                  rx_state <= RX_IDLE;
                  frame_fe <= !rx_bit;
                  frame_nf <= rx_noise | rx_disagree;
                  if (!rx_bit && !rx_break) begin
                    rx_hist <= HIST_ONES;
                  end
                end
              end
            end
          end
          default: rx_state <= RX_IDLE;
        endcase
      end
    end
  end

  // receive buffer and flags; a new character beats a same-cycle clear while no framing error is flagged
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rx_data <= 8'h00;
      rx_ninth <= 1'b0;
      rx_buffer_full_flag <= 1'b0;
      overrun_flag <= 1'b0;
      noise_flag <= 1'b0;
      framing_error_flag <= 1'b0;
      clear_armed <= 1'b0;
    end else begin
      if (rd_status && (rx_buffer_full_flag || overrun_flag ||
                        noise_flag || framing_error_flag)) begin
        clear_armed <= 1'b1;
      end
      if (clear_seq) begin
        rx_buffer_full_flag <= 1'b0;
        overrun_flag <= 1'b0;
        noise_flag <= 1'b0;
        framing_error_flag <= 1'b0;
        clear_armed <= 1'b0;
      end
      if (rx_done && !framing_error_flag) begin
        if (rx_buffer_full_flag && !clear_seq) begin
          overrun_flag <= 1'b1;
        end else begin
          rx_data <= nine_bit_mode ? rx_shift[7:0] : rx_shift[8:1];
          rx_ninth <= rx_shift[8];
          rx_buffer_full_flag <= 1'b1;
          noise_flag <= frame_nf;
          framing_error_flag <= frame_fe;
        end
      end
    end
  end

  always_comb begin
    status_byte = 8'h00;
    status_byte[S1_TX_EMPTY] = tx_buffer_empty_flag;
    status_byte[S1_TX_DONE] = tx_complete_flag;
    status_byte[S1_RX_FULL] = rx_buffer_full_flag;
    status_byte[S1_OVERRUN] = overrun_flag;
    status_byte[S1_NOISE] = noise_flag;
    status_byte[S1_FRAMING] = framing_error_flag;
    status_byte[S1_PARITY] = 1'b0;
  end

  // read data valid in the cycle after the strobe only
  always_ff @(posedge CLK) begin
    if (!RST_N || !RD) begin
      RDATA <= 8'h00;
    end else begin
      case (ADDR)
        REG_BAUD_LO: RDATA <= baud_div[7:0];
        REG_BAUD_HI: RDATA <= {3'h0, baud_div[12:8]};
        REG_CTRL1: RDATA <= {3'h0, nine_bit_mode, 3'h0, long_break_select};
        REG_CTRL2: RDATA <= {4'h0, tx_enable_bit, rx_enable_bit, 1'b0,
                             send_break_ctl};
        REG_STATUS1: RDATA <= status_byte;
        REG_CTRL3: RDATA <= {rx_ninth, tx_ninth_bit, rx_polarity_invert,
                             tx_polarity_invert, 4'h0};
        REG_DATA: RDATA <= rx_data;
        default: RDATA <= 8'h00;
      endcase
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  baud_stopped_a: assert property (baud_div == BAUD_RESET |=> !tick16)
    else $error("sample tick with zero divisor");
  // TXD lags the invert control by one edge, so compare with its old value
  tx_idle_level_a: assert property (!tx_busy && $stable(tx_polarity_invert)
      && $past(!tx_busy) |=> TXD == !$past(tx_polarity_invert))
    else $error("idle transmit level wrong");
  tx_empty_set_a: assert property (load_data |=> tx_buffer_empty_flag)
    else $error("empty flag not set on load");
  break_len_a: assert property (load_brk |=> tx_left ==
      ast_frame_len(nine_bit_mode, 1'b1, long_break_select) - 4'h1)
    else $error("break length wrong");
  break_low_a: assert property (load_brk && !tx_polarity_invert
      && tx_left == 4'h0 |=> ##1 !TXD)
    else $error("break not driven low");
  start_reject_a: assert property (rx_state == RX_START && tick16
      && rx_enable_bit && rt_n == SLOT_7 && start_zeros < START_MAJORITY
      |=> rx_state == RX_IDLE)
    else $error("noisy start accepted");
  overrun_keep_a: assert property (rx_done && rx_buffer_full_flag
      && !clear_seq && !framing_error_flag
      |=> overrun_flag && $stable(rx_data))
    else $error("overrun lost or data overwritten");
  fe_block_a: assert property (rx_done && framing_error_flag
      |=> $stable(rx_data))
    else $error("character stored during framing error");
  rx_clear_a: assert property (clear_seq && !rx_done
      |=> !rx_buffer_full_flag)
    else $error("receive-full not cleared");
  oe_hold_a: assert property (tx_busy |=> TX_OE)
    else $error("pin released during frame");

  tx_frame_c: cover property (load_data ##[1:1000] tx_done);
  rx_store_c: cover property (rx_done && !frame_fe && !rx_buffer_full_flag);
  rx_break_c: cover property (rx_done && frame_fe && rx_break);
  overrun_c: cover property (rx_done && rx_buffer_full_flag);

endmodule

// *** ast_remote.sv ***
// far-end serial device: sends frames on RXD, decodes frames from TXD
// assumes divisor 1, so one bit time is BIT_CLKS bus clocks
`timescale 1ns/1ps
module ast_remote #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clk,
  input wire logic txd,
  output logic rxd
);
  logic [7:0] rx_q[$];
  logic stop_q[$];
  int low_len = 0;
  int run = 0;
  initial rxd = 1'b1;
  // glitch flips one clock in mid data bit 0 so one vote disagrees
  task automatic send(input logic [7:0] d, input logic stop,
                      input logic glitch);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      for (int k = 0; k < BIT_CLKS; k++) begin
        @(posedge clk);
        rxd <= f[i] ^ (glitch && i == 1 && k == BIT_CLKS / 2);
      end
    end
    @(posedge clk);
    rxd <= 1'b1;
  endtask
  // short low pulse on an idle line, too brief to pass start validation
  task automatic pulse(input int n);
    @(posedge clk);
    rxd <= 1'b0;
    repeat (n) @(posedge clk);
    rxd <= 1'b1;
  endtask
  // length of the last low run, used to time breaks
  always @(posedge clk) begin
    if (txd === 1'b0) begin
      run <= run + 1;
    end else begin
      if (run != 0) begin
        low_len <= run;
      end
      run <= 0;
    end
  end
  // mid-bit sampling; the ninth sample sits where an 8-bit stop is
  initial begin
    logic [8:0] sh;
    forever begin
      @(negedge txd);
      repeat (BIT_CLKS / 2) @(posedge clk);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT_CLKS) @(posedge clk);
        sh = {txd, sh[8:1]};
      end
      rx_q.push_back(sh[7:0]);
      stop_q.push_back(sh[8]);
    end
  end
endmodule

// *** async_serial_transceiver_tb.sv ***
// self-checking bench for the serial transceiver with a far-end model
// assumes divisor 1: one bit is 16 bus clocks
`timescale 1ns/1ps
module async_serial_transceiver_tb
  import ast_pkg::*;
;
  localparam int BT = 16;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [2:0] ADDR = 3'h0;
  logic [7:0] WDATA = 8'h00;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [7:0] RDATA;
  logic RXD;
  logic TXD;
  logic TX_OE;
  int n_fail = 0;
  int checks = 0;
  always #20 CLK = ~CLK;
  ast_core DUT (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .RXD(RXD), .TXD(TXD), .TX_OE(TX_OE));
  // a released transmit line is pulled high, as the port pin would be
  ast_remote #(.BIT_CLKS(BT)) far_end (.clk(CLK),
    .txd(TX_OE ? TXD : 1'b1), .rxd(RXD));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk({8'h00, d}, {8'h00, exp});
  endtask
  task automatic wait_empty();
    logic [7:0] s;
    s = 8'h00;
    for (int t = 0; t < 400 && s[S1_TX_EMPTY] !== 1'b1; t++) begin
      rd(REG_STATUS1, s);
    end
    if (s[S1_TX_EMPTY] !== 1'b1) begin
      n_fail++;
      $display("FAIL %0t transmit buffer never emptied", $time);
    end
  endtask
  // a frame that never arrives counts as a mismatch
  task automatic wait_rx(input int n);
    for (int t = 0; t < 4000 && far_end.rx_q.size() < n; t++) begin
      @(posedge CLK);
    end
    if (far_end.rx_q.size() < n) begin
      n_fail++;
      $display("FAIL %0t far end received too few frames", $time);
    end
    repeat (80) @(posedge CLK);
  endtask
  task automatic flush();
    far_end.rx_q.delete();
    far_end.stop_q.delete();
  endtask
  task automatic t_reset();
    chk({15'h0, TXD}, 16'h0001);
    chk({15'h0, TX_OE}, 16'h0000);
    for (int a = 0; a < 8; a++) begin
      if (a != 6) begin
        rd_chk(a[2:0], a == 4 ? 8'hC0 : 8'h00);
      end
    end
    wr(REG_BAUD_LO, 8'h01);
    rd_chk(REG_BAUD_LO, 8'h01);
  endtask
  task automatic t_tx();
    int n;
    flush();
    wr(REG_CTRL2, 8'h08);
    wr(REG_DATA, 8'hA5);
    n = 0;
    while (TXD !== 1'b0 && n < 1000) begin
      @(posedge CLK);
      n++;
    end
    chk({15'h0, n >= 150}, 16'h0001);
    chk({15'h0, TX_OE}, 16'h0001);
    wait_empty();
    wr(REG_DATA, 8'h5A);
    wait_rx(2);
    chk({8'h0, far_end.rx_q[0]}, 16'h00A5);
    chk({8'h0, far_end.rx_q[1]}, 16'h005A);
    chk({15'h0, far_end.stop_q[1]}, 16'h0001);
    rd_chk(REG_STATUS1, 8'hC0);
  endtask
  task automatic t_nine();
    flush();
    wr(REG_CTRL1, 8'h10);
    wr(REG_CTRL3, 8'h00);
    wr(REG_DATA, 8'hFF);
    wait_rx(1);
    chk({8'h0, far_end.rx_q[0]}, 16'h00FF);
    chk({15'h0, far_end.stop_q[0]}, 16'h0000);
    wr(REG_CTRL1, 8'h00);
  endtask
  task automatic t_break(input logic lng, input int bits);
    flush();
    wr(REG_CTRL1, {7'h00, lng});
    // queue the break behind a frame in the shifter: the control is back
    // at zero long before the break loads, so no second break is queued
    wr(REG_DATA, 8'hFF);
    wait_empty();
    wr(REG_CTRL2, 8'h09);
    wr(REG_CTRL2, 8'h08);
    wait_rx(2);
    chk(far_end.low_len[15:0], 16'(bits * BT));
    wr(REG_CTRL1, 8'h00);
  endtask
  task automatic t_disable();
    flush();
    wr(REG_DATA, 8'h81);
    wait_empty();
    wr(REG_CTRL2, 8'h00);
    chk({15'h0, TX_OE}, 16'h0001);
    wait_rx(1);
    chk({8'h0, far_end.rx_q[0]}, 16'h0081);
    chk({15'h0, TX_OE}, 16'h0000);
    wr(REG_CTRL3, 8'h10);
    repeat (3) @(posedge CLK);
    chk({15'h0, TXD}, 16'h0000);
    wr(REG_CTRL3, 8'h00);
  endtask
  // status read arms the clear, data read completes it
  task automatic rx_case(input logic [7:0] d, input logic stop,
                         input logic gl, input logic [7:0] st,
                         input logic [7:0] ed);
    far_end.send(d, stop, gl);
    repeat (4) @(posedge CLK);
    rd_chk(REG_STATUS1, st);
    rd_chk(REG_DATA, ed);
    rd_chk(REG_STATUS1, 8'hC0);
  endtask
  task automatic t_rx();
    wr(REG_CTRL2, 8'h04);
    far_end.pulse(2);
    repeat (BT) @(posedge CLK);
    rd_chk(REG_STATUS1, 8'hC0);
    rx_case(8'h3C, 1'b1, 1'b0, 8'hE0, 8'h3C);
    far_end.send(8'h11, 1'b1, 1'b0);
    rx_case(8'h22, 1'b1, 1'b0, 8'hE8, 8'h11);
    rx_case(8'h66, 1'b1, 1'b1, 8'hE4, 8'h66);
    rx_case(8'h00, 1'b0, 1'b0, 8'hE2, 8'h00);
    far_end.send(8'h00, 1'b0, 1'b0);
    repeat (BT) @(posedge CLK);
    rx_case(8'h55, 1'b1, 1'b0, 8'hE2, 8'h00);
    wr(REG_CTRL2, 8'h00);
    far_end.send(8'h77, 1'b1, 1'b0);
    rd_chk(REG_STATUS1, 8'hC0);
  endtask
  task automatic give_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    #1;
    t_reset();
    t_tx();
    t_nine();
    t_break(1'b0, 10);
    t_break(1'b1, 13);
    t_disable();
    t_rx();
    give_verdict();
  end
  initial begin
    repeat (30000) @(posedge CLK);
    n_fail++;
    $display("FAIL %0t watchdog expired", $time);
    give_verdict();
  end
endmodule
